// file: hw/pci_reset_suspend_control.sv
// Reset, suspend-hold and slot power switch control of the card slot controller.
`timescale 1ns/1ns
`include "rst_susp_defs.svh"

module pci_reset_suspend_control #(
    parameter int BREAK_CYCLES = `BREAK_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rstn,
    input  wire logic                      suspend_hold,
    input  wire logic                      req_valid,
    input  wire rst_susp_pkg::supply_req_t req,
    output logic                           req_ready,
    output logic                           busy,
    output logic                           card_supply_select0,
    output logic                           card_supply_select1,
    output logic                           card_supply_oe,
    output logic                           prog_supply_select0,
    output logic                           prog_supply_select1,
    output logic                           prog_supply_oe
);
    import rst_susp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Retained supply selection.

    logic              keep_rst_n;
    logic              load;
    logic [`SEL_W-1:0] card_q;
    logic [`SEL_W-1:0] prog_q;
    seq_state_t        state_r;
    seq_state_t        state_nxt;
    logic [`CNT_W-1:0] cnt_r;
    logic [`CNT_W-1:0] cnt_nxt;
    logic              req_ready_r;
    logic              req_ready_nxt;
    logic              busy_r;
    logic              busy_nxt;
    supply_req_t       out_r;
    supply_req_t       out_nxt;
    logic              oe_r;
    logic              oe_nxt;

    // Suspend must lead reset; a late suspend lets the clear through.
    assign keep_rst_n = rstn | suspend_hold;

    // Requests taken at the clock edge.
    assign load = req_valid & req_ready_r & (state_r == ST_RUN);

    retained_reg #(
        .WIDTH     (`SEL_W),
        .RESET_VAL (`CARD_RST_VAL)
    ) u_card_sel (
        .clk        (ref_clk),
        .keep_rst_n (keep_rst_n),
        .load       (load),
        .d          (req.card),
        .q          (card_q)
    );

    // Kept unchanged during a suspended reset.
    retained_reg #(
        .WIDTH     (`SEL_W),
        .RESET_VAL (`PROG_RST_VAL)
    ) u_prog_sel (
        .clk        (ref_clk),
        .keep_rst_n (keep_rst_n),
        .load       (load),
        .d          (req.prog),
        .q          (prog_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Break-before-make sequencer and output drivers.

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            // Default state left one cycle after release.
            ST_OFF: begin
                state_nxt = ST_RUN;
            end
            // A new selection passes through the off code so the switch never
            // sees two supplies enabled at once.
            ST_BREAK: begin
                if (cnt_r == `CNT_W'(BREAK_CYCLES - 1)) begin
                    state_nxt = ST_RUN;
                    cnt_nxt   = '0;
                end else begin
                    cnt_nxt = cnt_r + `CNT_W'(1);
                end
            end
            ST_RUN: begin
                if (load) begin
                    state_nxt = ST_BREAK;
                    cnt_nxt   = '0;
                end
            end
        endcase
    end

    always_comb begin
        req_ready_nxt = (state_nxt == ST_RUN);
        busy_nxt      = (state_nxt != ST_RUN);
        oe_nxt        = 1'b1;
        // Card supply lines follow the retained value.
        // Programming supply lines follow the retained value.
        if (state_nxt == ST_RUN) begin
            out_nxt.card = card_q;
            out_nxt.prog = prog_q;
        end else begin
            out_nxt.card = `OFF_CODE;
            out_nxt.prog = `OFF_CODE;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r     <= ST_OFF;
            cnt_r       <= '0;
            req_ready_r <= 1'b0;
            busy_r      <= 1'b1;
            out_r       <= '0;
            oe_r        <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            req_ready_r <= req_ready_nxt;
            busy_r      <= busy_nxt;
            out_r       <= out_nxt;
            oe_r        <= oe_nxt;
        end
    end

    assign req_ready           = req_ready_r;
    assign busy                = busy_r;
    assign card_supply_select0 = out_r.card[0];
    assign card_supply_select1 = out_r.card[1];
    assign prog_supply_select0 = out_r.prog[0];
    assign prog_supply_select1 = out_r.prog[1];
    assign card_supply_oe      = oe_r;
    assign prog_supply_oe      = oe_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    take_request_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (req_valid && req_ready) |=> (card_q == $past(req.card)) &&
            (prog_q == $past(req.prog)) && !req_ready)
        else $error("accepted request not stored");

    reset_hiz_a: assert property (
        @(posedge ref_clk)
        !rstn |-> (!card_supply_oe && !prog_supply_oe))
        else $error("output enabled during reset");

    reset_clear_a: assert property (
        @(posedge ref_clk)
        (!rstn && !suspend_hold) ##1 (!rstn && !suspend_hold) |->
            (card_q == `CARD_RST_VAL) && (prog_q == `PROG_RST_VAL))
        else $error("registers not cleared by reset");

    reset_idle_a: assert property (
        @(posedge ref_clk)
        !rstn |-> (state_r == ST_OFF) && !req_ready && busy)
        else $error("activity during reset");

    release_start_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(rstn) |-> (state_r == ST_OFF) ##1 (state_r == ST_RUN) && card_supply_oe)
        else $error("wrong start after reset release");

    suspend_block_a: assert property (
        @(posedge ref_clk)
        (!rstn && suspend_hold) ##1 (!rstn && suspend_hold) |-> $stable(card_q))
        else $error("suspend did not block clear");

    suspend_keep_a: assert property (
        @(posedge ref_clk)
        (!rstn && suspend_hold) ##1 suspend_hold |->
            $stable(prog_q) && $stable(card_q) && !prog_supply_oe)
        else $error("suspended reset lost state or drove outputs");

    card_drive_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (state_r == ST_RUN) |->
            ({card_supply_select1, card_supply_select0} == card_q) && card_supply_oe)
        else $error("card supply lines differ from selection");

    prog_drive_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (state_r == ST_RUN) |->
            ({prog_supply_select1, prog_supply_select0} == prog_q) && prog_supply_oe)
        else $error("programming supply lines differ from selection");

    break_len_a: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (load && BREAK_CYCLES == 10) |=> busy [*8] ##1 busy ##1 busy ##1 !busy)
        else $error("break interval has wrong length");

    suspend_reset_c: cover property (
        @(posedge ref_clk) (!rstn && suspend_hold) ##1 rstn ##2 (state_r == ST_RUN));

    request_c: cover property (
        @(posedge ref_clk) disable iff (!rstn) load ##[1:20] (state_r == ST_RUN));

    plain_reset_c: cover property (
        @(posedge ref_clk) (!rstn && !suspend_hold) ##1 rstn);

endmodule : pci_reset_suspend_control

// file: hw/rst_susp_defs.svh
// Constants of the reset, suspend-hold and slot power switch control block.
//
// Contract
// - Sample all inputs on rising clock edge; the code acts on rstn and suspend_hold asynchronously.
// - Bus reset forces every output to high impedance; the code drives OE and select lines low and busy high instead.
// - Reset without suspend clears every register.
// - After reset release, start from default state.
// - Suspend with reset blocks register clearing.
// - Suspended reset: outputs off, registers kept.
// - Drive two card supply select lines.
// - Drive two programming supply select lines.
`ifndef RST_SUSP_DEFS_SVH
`define RST_SUSP_DEFS_SVH

`define SEL_W          2
`define CARD_RST_VAL   2'h0
`define PROG_RST_VAL   2'h0
`define OFF_CODE       2'h0
`define CLK_PERIOD_NS  40
`define BREAK_NS       400
`define BREAK_CYC      ((`BREAK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W          8

`endif

// file: hw/rst_susp_pkg.sv
// Types shared by the reset, suspend-hold and slot power switch control block.
`include "rst_susp_defs.svh"

package rst_susp_pkg;

    typedef struct packed {
        logic [`SEL_W-1:0] card;
        logic [`SEL_W-1:0] prog;
    } supply_req_t;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_BREAK,
        ST_RUN
    } seq_state_t;

endpackage : rst_susp_pkg

// file: hw/retained_reg.sv
// Register that survives a bus reset taken while suspend-hold is high.
`timescale 1ns/1ns

module retained_reg #(
    parameter int               WIDTH     = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             keep_rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (load) begin
            q_nxt = d;
        end
    end

    // The clear only reaches this flop when suspend-hold is low.
    always_ff @(posedge clk or negedge keep_rst_n) begin
        if (!keep_rst_n) begin
            q_r <= RESET_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule : retained_reg

// file: verif/slot_switch_model.sv
// Behavioural model of the external slot power switch fed by the select lines.
`timescale 1ns/1ns

module slot_switch_model (
    input  wire logic       card_sel0,
    input  wire logic       card_sel1,
    input  wire logic       card_oe,
    input  wire logic       prog_sel0,
    input  wire logic       prog_sel1,
    input  wire logic       prog_oe,
    output logic      [1:0] switched_card_supply,
    output logic      [1:0] switched_prog_supply
);
    // Undriven control inputs are held low by pull-downs, which selects no supply.
    // card supply select
    assign switched_card_supply = card_oe ? {card_sel1, card_sel0} : 2'h0;
    assign switched_prog_supply = prog_oe ? {prog_sel1, prog_sel0} : 2'h0;
endmodule : slot_switch_model

// file: verif/tb_top.sv
// Self-checking bench of the reset, suspend-hold and power switch control.
`timescale 1ns/1ns
`include "rst_susp_defs.svh"

module tb_top;
    import rst_susp_pkg::*;
    localparam int          BRK = `BREAK_CYC;
    localparam supply_req_t OFF = {`OFF_CODE, `OFF_CODE};
    localparam supply_req_t DEF = {`CARD_RST_VAL, `PROG_RST_VAL};
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b1;
    logic        suspend_hold = 1'b0;
    logic        req_valid = 1'b0;
    supply_req_t req = '0;
    supply_req_t r, held;
    logic        req_ready, busy, c0, c1, coe, p0, p1, poe;
    logic [1:0]  sw_card, sw_prog;
    logic [9:0]  obs;
    int          failures = 0;
    int          num_checks = 0;
    int          seed = 37;

    always #20 ref_clk = ~ref_clk;
    assign obs = {coe, c1, c0, poe, p1, p0, sw_card, sw_prog};

    pci_reset_suspend_control #(.BREAK_CYCLES(BRK)) DUT (
        .ref_clk(ref_clk), .rstn(rstn), .suspend_hold(suspend_hold),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .busy(busy),
        .card_supply_select0(c0), .card_supply_select1(c1), .card_supply_oe(coe),
        .prog_supply_select0(p0), .prog_supply_select1(p1), .prog_supply_oe(poe));

    slot_switch_model sw (
        .card_sel0(c0), .card_sel1(c1), .card_oe(coe),
        .prog_sel0(p0), .prog_sel1(p1), .prog_oe(poe),
        .switched_card_supply(sw_card), .switched_prog_supply(sw_prog));

    function automatic logic [9:0] exp_pins(supply_req_t s, logic on);
        return {on, s.card, on, s.prog, on ? s.card : 2'h0, on ? s.prog : 2'h0};
    endfunction : exp_pins

    task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic check_pins(input logic [9:0] exp);
        cmp(obs, exp, "pins");
    endtask : check_pins

    task automatic check_flags(input logic [1:0] exp);
        cmp({8'h0, req_ready, busy}, {8'h0, exp}, "ready/busy");
    endtask : check_flags

    task automatic request(input supply_req_t s);
        int n;
        n = 0;
        @(negedge ref_clk);
        req = s;
        req_valid = 1'b1;
        @(negedge ref_clk);
        held = s;
        check_pins(exp_pins(OFF, 1'b1));
        check_flags(2'b01);
        req = ~s;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        req_valid = 1'b0;
        cmp(10'(n), 10'(BRK), "break length");
        check_pins(exp_pins(s, 1'b1));
    endtask : request

    task automatic do_reset(input logic keep);
        @(negedge ref_clk);
        suspend_hold = keep;
        @(negedge ref_clk);
        rstn = 1'b0;
        repeat (4) @(negedge ref_clk);
        req = 4'hf;
        req_valid = 1'b1;
        repeat (4) @(negedge ref_clk);
        check_pins(exp_pins(OFF, 1'b0));
        check_flags(2'b01);
        req_valid = 1'b0;
        rstn = 1'b1;
        @(negedge ref_clk);
        check_pins(exp_pins(keep ? held : DEF, 1'b1));
        check_flags(2'b10);
        suspend_hold = 1'b0;
        if (!keep) begin
            held = DEF;
        end
        $display("test reset keep=%0b done", keep);
    endtask : do_reset

    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        // Give the asynchronous reset a real falling edge before the first clock.
        rstn <= 1'b0;
        repeat (8) @(negedge ref_clk);
        check_pins(exp_pins(OFF, 1'b0));
        check_flags(2'b01);
        rstn = 1'b1;
        @(negedge ref_clk);
        check_pins(exp_pins(DEF, 1'b1));
        $display("test reset release done");
        request(4'hf);
        request(4'h0);
        for (int i = 0; i < 12; i++) begin
            r = 4'($random(seed));
            request(r);
        end
        $display("test random requests done");
        request(4'h9);
        do_reset(1'b1);
        request(4'h6);
        do_reset(1'b0);
        request(4'ha);
        do_reset(1'b1);
        results();
    end

    initial begin
        #(2000 * 40);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule : tb_top
